//--- utm_pkg.sv
package utm_pkg;
  // Command codes of the three registers
  localparam logic [7:0] UTM_CMD_WARN = 8'h52;
  localparam logic [7:0] UTM_CMD_FAULT = 8'h53;
  localparam logic [7:0] UTM_CMD_ACTION = 8'h54;
  // Field positions in the action byte
  localparam int UTM_RESP_LSB = 6;
  localparam int UTM_RETRY_LSB = 3;
  localparam int UTM_DELAY_LSB = 0;
  // Reset values (plain defaults)
  localparam logic [15:0] UTM_WARN_RST = 16'h0000;
  localparam logic [15:0] UTM_FAULT_RST = 16'h0000;
  localparam logic [7:0] UTM_ACTION_RST = 8'h00;
  // Response codes
  localparam logic [1:0] UTM_RESP_IGNORE = 2'h0;
  localparam logic [1:0] UTM_RESP_RUN_DELAY = 2'h1;
  localparam logic [1:0] UTM_RESP_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] UTM_RESP_LATCH_OFF = 2'h3;
  // Retry codes
  localparam logic [2:0] UTM_RETRY_NONE = 3'h0;
  localparam logic [2:0] UTM_RETRY_FOREVER = 3'h7;
  typedef enum logic [2:0] {
    UTM_IDLE, UTM_RUN_WAIT, UTM_OFF_WAIT, UTM_RESTART, UTM_LATCHED
  } utm_state_t;
endpackage

//--- utm_monitor.sv
`timescale 1ns/1ns
module utm_monitor #(
  parameter int UNIT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Command port from the PMBus decoder
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_hit,
  // Fault clearing sources
  input wire logic clear_status,
  input wire logic clear_faults,
  input wire logic output_on_cmd,
  // Delay time unit length in clocks, less one, from the separate unit register
  input wire logic [UNIT_W-1:0] unit_clocks,
  // Temperature from the sensing path, same clock
  input wire logic temp_valid,
  input wire logic [15:0] temp_meas,
  // Results
  output logic warn_flag,
  output logic fault_flag,
  output logic output_enable
);
  import utm_pkg::*;

  logic [15:0] warn_reg;
  logic [15:0] fault_thr_reg;
  logic [7:0] action_reg;
  logic below_warn;
  logic below_fault;
  logic [1:0] resp;
  logic [2:0] retry;
  logic [2:0] delay_n;
  logic [7:0] units_target;
  logic [7:0] unit_cnt_reg;
  logic [UNIT_W-1:0] tick_cnt_reg;
  logic unit_tick;
  logic [2:0] tries_reg;
  logic on_sync1_reg;
  logic on_sync2_reg;
  logic on_d_reg;
  logic output_off;
  logic on_rise;
  logic clear_any;
  logic start_timer;
  logic timer_done;
  utm_state_t state_reg;

  // Warning threshold, written whole
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      warn_reg <= UTM_WARN_RST;
    else if (clk_en && cmd_wr && (cmd_code == UTM_CMD_WARN))
      warn_reg <= cmd_wdata;
  end

  // Fault threshold, written whole
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_thr_reg <= UTM_FAULT_RST;
    else if (clk_en && cmd_wr && (cmd_code == UTM_CMD_FAULT))
      fault_thr_reg <= cmd_wdata;
  end

  // Action byte; the upper data byte has no home and is dropped.
  // A new action takes effect at once, even in the middle of a response.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      action_reg <= UTM_ACTION_RST;
    else if (clk_en && cmd_wr && (cmd_code == UTM_CMD_ACTION))
      action_reg <= cmd_wdata[7:0];
  end

  // Readback, combinational handshake
  always_comb
  begin
    cmd_hit = 1'b1;
    cmd_rdata = 16'h0000;
    case (cmd_code)
      UTM_CMD_WARN: cmd_rdata = warn_reg;
      UTM_CMD_FAULT: cmd_rdata = fault_thr_reg;
      UTM_CMD_ACTION: cmd_rdata = {8'h00, action_reg};
      default: cmd_hit = 1'b0;
    endcase
  end

  assign resp = action_reg[UTM_RESP_LSB +: 2];
  assign retry = action_reg[UTM_RETRY_LSB +: 3];
  assign delay_n = action_reg[UTM_DELAY_LSB +: 3];
  // Thresholds compared as signed raw codes; the sensing path must deliver
  // the temperature in the same linear exponent as the thresholds.
  assign below_warn = $signed(temp_meas) < $signed(warn_reg);
  assign below_fault = $signed(temp_meas) < $signed(fault_thr_reg);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      warn_flag <= 1'b0;
    else if (clk_en && temp_valid)
      warn_flag <= below_warn;
  end

  // The on command comes from a pin: two flops before any logic reads it.
  // Both reset to on, its idle level, so leaving reset is no false edge.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_sync1_reg <= 1'b1;
      on_sync2_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      on_sync1_reg <= output_on_cmd;
      on_sync2_reg <= on_sync1_reg;
    end
  end

  // Off-then-on detection of the synchronised command
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      on_d_reg <= 1'b1;
    else if (clk_en)
      on_d_reg <= on_sync2_reg;
  end
  assign on_rise = on_sync2_reg && !on_d_reg;
  // Loss of bias power reaches us as the asynchronous reset
  assign clear_any = clear_status || clear_faults || on_rise;

  // Delay timer: 2**n units of unit_clocks+1 clocks each.
  // One timer serves both the run delay and the retry spacing,
  // since the sequencer never needs both at once.
  assign units_target = 8'h01 << delay_n;
  assign unit_tick = (tick_cnt_reg >= unit_clocks);
  assign timer_done = unit_tick && (unit_cnt_reg >= units_target - 8'h01);

  // Clocks within the current unit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_reg <= '0;
    else if (clk_en)
    begin
      if (start_timer || unit_tick)
        tick_cnt_reg <= '0;
      else
        tick_cnt_reg <= tick_cnt_reg + {{(UNIT_W-1){1'b0}}, 1'b1};
    end
  end

  // Whole units elapsed; 8 bits cover the longest delay of 128 units
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      unit_cnt_reg <= 8'h00;
    else if (clk_en)
    begin
      if (start_timer || timer_done)
        unit_cnt_reg <= 8'h00;
      else if (unit_tick)
        unit_cnt_reg <= unit_cnt_reg + 8'h01;
    end
  end

  // Timer restarts on every entry into a waiting state
  assign start_timer = (state_reg == UTM_IDLE) || (state_reg == UTM_RESTART);

  // Restart attempts since the fault was taken.
  // Wraps under unlimited retry, where the count is never consulted.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tries_reg <= 3'h0;
    else if (clk_en)
    begin
      if (state_reg == UTM_IDLE)
        tries_reg <= 3'h0;
      else if ((state_reg == UTM_OFF_WAIT) && !clear_any && timer_done)
        tries_reg <= tries_reg + 3'h1;
    end
  end

  // Fault response sequencer.
  // A restart counts as failed when the next sample is still below the
  // fault threshold; without a fresh sample the output stays on and waits.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= UTM_IDLE;
    else if (clk_en)
    begin
      case (state_reg)
        UTM_IDLE:
        begin
          if (temp_valid && below_fault)
          begin
            case (resp)
              UTM_RESP_IGNORE: state_reg <= UTM_IDLE;
              UTM_RESP_RUN_DELAY: state_reg <= UTM_RUN_WAIT;
              UTM_RESP_DISABLE_RETRY:
                state_reg <= (retry == UTM_RETRY_NONE) ? UTM_LATCHED : UTM_OFF_WAIT;
              default: state_reg <= UTM_LATCHED;
            endcase
          end
        end
        // Output stays on while the run delay counts down
        UTM_RUN_WAIT:
        begin
          if (clear_any || (temp_valid && !below_fault))
            state_reg <= UTM_IDLE;
          else if (timer_done)
            state_reg <= (retry == UTM_RETRY_NONE) ? UTM_LATCHED : UTM_OFF_WAIT;
        end
        // Output off while the spacing to the next attempt runs
        UTM_OFF_WAIT:
        begin
          if (clear_any)
            state_reg <= UTM_IDLE;
          else if (timer_done)
            state_reg <= UTM_RESTART;
        end
        UTM_RESTART:
        begin
          // One sample decides whether the restart held
          if (clear_any || (temp_valid && !below_fault))
            state_reg <= UTM_IDLE;
          else if (temp_valid)
          begin
            if (retry == UTM_RETRY_FOREVER || tries_reg < retry)
              state_reg <= UTM_OFF_WAIT;
            else
              state_reg <= UTM_LATCHED;
          end
        end
        UTM_LATCHED:
        begin
          if (clear_any)
            state_reg <= UTM_IDLE;
        end
        default: state_reg <= UTM_IDLE;
      endcase
    end
  end

  assign output_off = (state_reg == UTM_OFF_WAIT) || (state_reg == UTM_LATCHED);

  // Sticky fault flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_flag <= 1'b0;
    else if (clk_en)
    begin
      // Set wins over a clear arriving in the same cycle
      if (temp_valid && below_fault)
        fault_flag <= 1'b1;
      else if (clear_any)
        fault_flag <= 1'b0;
    end
  end

  // Registered so the power stage never sees a decode glitch.
  // Costs one cycle of reaction time, no more than the shortest delay unit of one clock.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      output_enable <= 1'b1;
    else if (clk_en)
      output_enable <= !output_off;
  end
endmodule

//--- utm_chk.sv
`timescale 1ns/1ns
module utm_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Command port
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_hit,
  // Clears and temperature
  input wire logic clear_status,
  input wire logic clear_faults,
  input wire logic output_on_cmd,
  input wire logic temp_valid,
  input wire logic [15:0] temp_meas,
  // Results
  input wire logic warn_flag,
  input wire logic fault_flag,
  input wire logic output_enable
);
  import utm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] warn_reg;
  logic [15:0] fault_reg;
  logic [7:0] act_reg;
  logic wr;
  logic below;
  assign wr = clk_en && cmd_wr;
  assign below = clk_en && temp_valid && ($signed(temp_meas) < $signed(fault_reg));
  // Shadow copies, since the checker cannot see the register bodies
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      warn_reg <= UTM_WARN_RST;
      fault_reg <= UTM_FAULT_RST;
      act_reg <= UTM_ACTION_RST;
    end
    else if (wr)
    begin
      if (cmd_code == UTM_CMD_WARN)
        warn_reg <= cmd_wdata;
      if (cmd_code == UTM_CMD_FAULT)
        fault_reg <= cmd_wdata;
      if (cmd_code == UTM_CMD_ACTION)
        act_reg <= cmd_wdata[7:0];
    end
  AST_HIT: assert property (cmd_hit == (cmd_code inside {8'h52, 8'h53, 8'h54}))
    else $error("hit flag wrong");
  AST_UNMAP: assert property (!cmd_hit |-> cmd_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_WR: assert property (wr && cmd_code == 8'h53 ##1 cmd_code == 8'h53 |-> cmd_rdata == $past(cmd_wdata))
    else $error("threshold readback wrong");
  AST_IGN: assert property (act_reg[7:6] == 2'h0 && output_enable && !fault_flag |=> output_enable)
    else $error("ignored fault dropped output");
  AST_FAULT: assert property (below |=> fault_flag)
    else $error("fault not flagged");
  AST_WARN: assert property (clk_en && temp_valid |=>
    warn_flag == ($signed($past(temp_meas)) < $signed($past(warn_reg))))
    else $error("warning flag wrong");
  AST_OFF: assert property (below && act_reg[7] && !fault_flag |-> ##[1:3] !output_enable)
    else $error("output not disabled");
  AST_HOLD: assert property (fault_flag && !output_enable && act_reg[7:6] == 2'h3 && !clear_status
    && !clear_faults && !$rose(output_on_cmd) |=> !output_enable)
    else $error("latched output came back");
  AST_CLR: assert property (clk_en && (clear_status || clear_faults)
    && !below |=> !fault_flag)
    else $error("fault not cleared");
  AST_ONCLR: assert property ($rose(output_on_cmd) && !below ##1 !below ##1 !below
    |=> !fault_flag)
    else $error("off-then-on did not clear fault");
  cover property (below && act_reg[7:6] == 2'h3);
  cover property ($rose(output_enable) && fault_flag);
  cover property (warn_flag && !fault_flag);
endmodule
bind utm_monitor utm_chk u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_wr(cmd_wr),
  .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_hit(cmd_hit),
  .clear_status(clear_status), .clear_faults(clear_faults), .output_on_cmd(output_on_cmd),
  .temp_valid(temp_valid), .temp_meas(temp_meas), .warn_flag(warn_flag),
  .fault_flag(fault_flag), .output_enable(output_enable));

//--- utm_host.sv
`timescale 1ns/1ns
module utm_host (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_wr = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic [15:0] cmd_wdata = 16'h0000,
  input wire logic [15:0] cmd_rdata,
  // Clear-all command
  output logic clear_faults = 1'b0
);
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    // Data is not held after the write, so show a different value
    cmd_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] q);
    @(posedge clk);
    cmd_code <= c;
    @(posedge clk);
    #1;
    q = cmd_rdata;
  endtask
  task automatic clr();
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import utm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clear_status = 1'b0;
  logic output_on_cmd = 1'b1;
  logic temp_valid = 1'b0;
  logic [15:0] unit_clocks = 16'h0000;
  logic [15:0] temp_meas = 16'h0020;
  logic cmd_wr, cmd_hit, clear_faults, warn_flag, fault_flag, output_enable;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, q;
  int n_errors = 0;
  int n_compared = 0;
  // Code, write data, expected readback
  logic [39:0] rows [4] = '{40'h52_F00D_F00D, 40'h53_8005_8005, 40'h54_1234_0034, 40'h55_FFFF_0000};
  logic [2:0] rc [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
  utm_host h (.clk(clk), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .clear_faults(clear_faults));
  utm_monitor dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_hit(cmd_hit), .clear_status(clear_status),
    .clear_faults(clear_faults), .output_on_cmd(output_on_cmd), .unit_clocks(unit_clocks),
    .temp_valid(temp_valid), .temp_meas(temp_meas), .warn_flag(warn_flag),
    .fault_flag(fault_flag), .output_enable(output_enable));
  initial
    forever #2 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tmp(input logic [15:0] t);
    @(posedge clk);
    temp_valid <= 1'b1;
    temp_meas <= t;
    @(posedge clk);
    temp_valid <= 1'b0;
    temp_meas <= ~t;
  endtask
  task automatic wt(input logic v);
    for (int i = 0; i < 60 && output_enable !== v; i++)
      @(posedge clk) #1;
    chk(output_enable, v);
  endtask
  initial
  begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      h.wr(rows[i][39:32], rows[i][31:16]);
      h.rd(rows[i][39:32], q);
      chk(q, rows[i][15:0]);
      chk(cmd_hit, rows[i][39:32] != 8'h55);
    end
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      h.rd(rows[i][39:32], q);
      chk(q, 16'h0000);
    end
    chk(output_enable, 1'b1);
    h.wr(UTM_CMD_WARN, 16'h0010);
    h.wr(UTM_CMD_FAULT, 16'h0005);
    tmp(16'h0008);
    @(posedge clk) #1;
    chk(warn_flag, 1'b1);
    chk(fault_flag, 1'b0);
    tmp(16'h0000);
    repeat (5) @(posedge clk);
    #1;
    chk(output_enable, 1'b1);
    chk(fault_flag, 1'b1);
    h.clr();
    @(posedge clk) #1;
    chk(fault_flag, 1'b0);
    h.wr(UTM_CMD_ACTION, 16'h00C0);
    tmp(16'h0000);
    wt(1'b0);
    repeat (20) @(posedge clk);
    #1;
    chk(output_enable, 1'b0);
    @(posedge clk);
    clear_status <= 1'b1;
    @(posedge clk);
    clear_status <= 1'b0;
    wt(1'b1);
    // Four units of two clocks: a linear delay would drop at six
    @(posedge clk);
    unit_clocks <= 16'h0001;
    h.wr(UTM_CMD_ACTION, 16'h0042);
    @(posedge clk);
    temp_valid <= 1'b1;
    temp_meas <= 16'h0000;
    repeat (7)
    begin
      @(posedge clk) #1;
      chk(output_enable, 1'b1);
    end
    wt(1'b0);
    @(posedge clk);
    temp_valid <= 1'b0;
    h.clr();
    wt(1'b1);
    @(posedge clk);
    unit_clocks <= 16'h0000;
    foreach (rc[j])
    begin
      h.wr(UTM_CMD_ACTION, {8'h00, 2'h2, rc[j], 3'h0});
      tmp(16'h0000);
      wt(1'b0);
      repeat ((rc[j] == UTM_RETRY_FOREVER) ? 8 : int'(rc[j]))
      begin
        wt(1'b1);
        tmp(16'h0000);
        wt(1'b0);
      end
      repeat (20) @(posedge clk);
      #1;
      chk(output_enable, rc[j] == UTM_RETRY_FOREVER);
      @(posedge clk);
      output_on_cmd <= 1'b0;
      @(posedge clk);
      output_on_cmd <= 1'b1;
      wt(1'b1);
    end
    stop_test();
  end
endmodule
